//--- core/cmf_ahb.sv
`timescale 1ns/1ps
module cmf_ahb
  import cmf_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic             o_rd_en,
  output logic [31:0]      o_rd_addr,
  output logic             o_wr_en,
  output logic [31:0]      o_wr_addr,
  output logic [7:0]       o_wr_data
);

  // ==========================================================================
  // Address phase capture
  cmf_bus_t bus_ff;
  cmf_bus_t nxt_bus;
  logic     take;

  // Zero wait states: every selected NONSEQ or SEQ address phase seen with hready is taken
  assign take      = i_hsel && i_hready && i_htrans[1];
  assign o_rd_en   = take && !i_hwrite;
  assign o_rd_addr = i_haddr;
  // Writes land in the data phase, when hwdata stands
  assign o_wr_en   = bus_ff.wr_pend;
  assign o_wr_addr = bus_ff.waddr;
  assign o_wr_data = i_hwdata[7:0];

  always_comb begin
    nxt_bus         = bus_ff;
    nxt_bus.wr_pend = take && i_hwrite;
    if (take) begin
      nxt_bus.waddr = i_haddr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus_ff <= '0;
    end else begin
      bus_ff <= nxt_bus;
    end
  end

endmodule

//--- core/cmf_pkg.sv
// Functional notes
// - With receive enable set, incoming messages are taken into the receive queue.
// - Clearing receive enable stops reception, discards the queue, raises receive empty.
// - A write of zero to receive enable is ignored from CRC start.
// - Queue selected: protection ends at store or bus error, at most 7th EOF bit.
// - Queue not selected: protection ends when acceptance filtering finishes.
// - Writing all ones to pointer advance moves the read pointer when not empty.
// - Overwrite mode, full queue, new message: both pointers advance.
// - In that overwrite case with lost flag set, pointer advance writes are ignored.
// - Transmit empty is set at zero unsent or after abort, else cleared.
// - Transmit full is set at four unsent, cleared below four or on abort.
// - Unsent count sits in bits three to one, codes 000 to 100.
// - Transmit enable one enables the transmit queue, zero disables it.
// - Clearing transmit enable empties queue; active message dropped after it finishes.
// - Message into a full receive queue sets lost flag at 6th EOF bit end.
// - Unread count uses codes 000 to 100 and resets when receive enable clears.
package cmf_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  localparam logic [31:0] RXQ_CTRL_IDX  = 32'hffff6848;
  localparam logic [31:0] RXQ_ADV_IDX   = 32'hffff6849;
  localparam logic [31:0] TXQ_CTRL_IDX  = 32'hffff684a;
  localparam logic [31:0] IRQ_STAT_IDX  = 32'hffff684c;
  localparam logic [31:0] IRQ_EN_IDX    = 32'hffff684d;
  localparam logic [31:0] IRQ_CLR_IDX   = 32'hffff684e;
  localparam logic [31:0] ADDR_RXQ_CTRL = RXQ_CTRL_IDX << 2;
  localparam logic [31:0] ADDR_RXQ_ADV  = RXQ_ADV_IDX << 2;
  localparam logic [31:0] ADDR_TXQ_CTRL = TXQ_CTRL_IDX << 2;
  localparam logic [31:0] ADDR_IRQ_STAT = IRQ_STAT_IDX << 2;
  localparam logic [31:0] ADDR_IRQ_EN   = IRQ_EN_IDX << 2;
  localparam logic [31:0] ADDR_IRQ_CLR  = IRQ_CLR_IDX << 2;

  // ==========================================================================
  // Field positions
  localparam int unsigned BIT_EMPTY     = 7;
  localparam int unsigned BIT_RX_WARN   = 6;
  localparam int unsigned BIT_RX_FULL   = 5;
  localparam int unsigned BIT_RX_LOST   = 4;
  localparam int unsigned BIT_TX_FULL   = 6;
  localparam int unsigned CNT_LSB       = 1;
  localparam int unsigned BIT_ENABLE    = 0;
  localparam logic [7:0]  ADV_KEY       = 8'hff;
  localparam logic [7:0]  TXQ_RESET     = 8'h80;
  localparam logic [7:0]  RXQ_RESET     = 8'h80;

  // ==========================================================================
  // Counts and interrupt layout
  localparam logic [2:0]  CNT_FULL      = 3'h4;
  localparam logic [2:0]  CNT_WARN      = 3'h3;
  localparam logic [2:0]  LOST_PROT_CYC = 3'h5;
  localparam int unsigned IRQ_N         = 4;
  localparam int unsigned IRQ_RX_MSG    = 0;
  localparam int unsigned IRQ_RX_LOST   = 1;
  localparam int unsigned IRQ_TX_SENT   = 2;
  localparam int unsigned IRQ_TX_ABORT  = 3;

  typedef struct packed {
    logic              wr_pend;
    logic [31:0]       waddr;
  } cmf_bus_t;

  typedef struct packed {
    logic              rx_queue_enable;
    logic              rx_prot;
    logic              rx_sel;
    logic              rx_lost;
    logic [2:0]        lost_hold;
    logic [1:0]        rx_wr;
    logic [1:0]        rx_rd;
    logic [2:0]        rx_cnt;
    logic              tx_queue_enable;
    logic              tx_abort_pend;
    logic              tx_aborted;
    logic [1:0]        tx_wr;
    logic [1:0]        tx_rd;
    logic [2:0]        tx_cnt;
    logic [IRQ_N-1:0]  irq_stat;
    logic [IRQ_N-1:0]  irq_en;
    logic              irq;
    logic [31:0]       rdata;
  } cmf_state_t;

endpackage

//--- core/cmf_top.sv
`timescale 1ns/1ps
module cmf_top
  import cmf_pkg::*;
#(
  parameter int unsigned QDEPTH = 4
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // Receive events from the protocol engine
  input  wire logic        i_crc_start,
  input  wire logic        i_filter_done,
  input  wire logic        i_rx_to_queue,
  input  wire logic        i_eof6_end,
  input  wire logic        i_eof7_end,
  input  wire logic        i_rx_stored,
  input  wire logic        i_bus_error,
  input  wire logic        i_overwrite_mode,
  // Transmit events
  input  wire logic        i_tx_push,
  input  wire logic        i_tx_scheduled,
  input  wire logic        i_tx_sent,
  input  wire logic        i_tx_arb_lost,
  input  wire logic        i_halt_entry,
  // Queue state toward the engine and mailbox storage
  output logic             o_rx_accept,
  output logic [1:0]       o_rx_wr_ptr,
  output logic [1:0]       o_rx_rd_ptr,
  output logic             o_tx_enable,
  output logic [1:0]       o_tx_wr_ptr,
  output logic [1:0]       o_tx_rd_ptr,
  output logic             o_irq
);

  // ==========================================================================
  // Elaboration checks
  // Count codes 000..100 and two-bit pointers only serve four entries
  if (QDEPTH != 4) begin : g_depth_chk
    $error("cmf_top: QDEPTH must be 4");
  end

  // ==========================================================================
  // Bus front end
  logic        rd_en;
  logic [31:0] rd_addr;
  logic        wr_en;
  logic [31:0] wr_addr;
  logic [7:0]  wr_data;

  cmf_ahb u_ahb (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_hsel    (i_hsel),
    .i_haddr   (i_haddr),
    .i_htrans  (i_htrans),
    .i_hwrite  (i_hwrite),
    .i_hready  (i_hready),
    .i_hwdata  (i_hwdata),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data)
  );

  cmf_state_t st_ff;
  cmf_state_t nxt;

  logic wr_rxq;
  logic wr_adv;
  logic wr_txq;
  logic wr_ien;
  logic wr_iclr;

  assign wr_rxq  = wr_en && (wr_addr == ADDR_RXQ_CTRL);
  assign wr_adv  = wr_en && (wr_addr == ADDR_RXQ_ADV);
  assign wr_txq  = wr_en && (wr_addr == ADDR_TXQ_CTRL);
  assign wr_ien  = wr_en && (wr_addr == ADDR_IRQ_EN);
  assign wr_iclr = wr_en && (wr_addr == ADDR_IRQ_CLR);

  // ==========================================================================
  // Status views
  logic       rx_empty;
  logic       rx_full;
  logic       tx_full;
  logic       tx_empty;
  logic [7:0] rxq_view;
  logic [7:0] txq_view;

  assign rx_empty = (st_ff.rx_cnt == 3'h0);
  assign rx_full  = (st_ff.rx_cnt == CNT_FULL);
  assign tx_empty = (st_ff.tx_cnt == 3'h0) || st_ff.tx_aborted;
  assign tx_full  = (st_ff.tx_cnt == CNT_FULL) && !st_ff.tx_aborted;

  always_comb begin
    rxq_view                          = '0;
    rxq_view[BIT_EMPTY]               = rx_empty;
    rxq_view[BIT_RX_WARN]             = (st_ff.rx_cnt == CNT_WARN);
    rxq_view[BIT_RX_FULL]             = rx_full;
    rxq_view[BIT_RX_LOST]             = st_ff.rx_lost;
    rxq_view[CNT_LSB+2:CNT_LSB]       = st_ff.rx_cnt;
    rxq_view[BIT_ENABLE]              = st_ff.rx_queue_enable;
    txq_view                          = '0;
    txq_view[BIT_EMPTY]               = tx_empty;
    txq_view[BIT_TX_FULL]             = tx_full;
    txq_view[CNT_LSB+2:CNT_LSB]       = st_ff.tx_cnt;
    txq_view[BIT_ENABLE]              = st_ff.tx_queue_enable;
  end

  // ==========================================================================
  // Interrupt status: set beats a clear in the same cycle
  logic [IRQ_N-1:0] irq_evt;
  logic [IRQ_N-1:0] nxt_stat;
  logic             rx_take;
  logic             lost_evt;
  logic             tx_abort_done;

  assign irq_evt[IRQ_RX_MSG]   = rx_take;
  assign irq_evt[IRQ_RX_LOST]  = lost_evt;
  assign irq_evt[IRQ_TX_SENT]  = i_tx_sent && (st_ff.tx_cnt != 3'h0);
  assign irq_evt[IRQ_TX_ABORT] = tx_abort_done;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
      assign nxt_stat[gi] = irq_evt[gi] || (st_ff.irq_stat[gi] && !(wr_iclr && wr_data[gi]));
    end
  endgenerate

  // ==========================================================================
  // Receive side events
  logic rx_arrive;
  logic ovw_block;
  logic adv_ok;

  assign rx_arrive = i_rx_stored && st_ff.rx_queue_enable && st_ff.rx_sel;
  assign rx_take   = rx_arrive && (!rx_full || i_overwrite_mode);
  // lost flag at end of 6th EOF bit
  assign lost_evt  = i_eof6_end && st_ff.rx_queue_enable && st_ff.rx_sel && rx_full;
  // overwrite, full queue and lost block read pointer advance writes
  assign ovw_block = i_overwrite_mode && rx_full && st_ff.rx_lost;
  assign adv_ok    = wr_adv && (wr_data == ADV_KEY) && st_ff.rx_queue_enable && !rx_empty && !ovw_block;

  // ==========================================================================
  // Transmit abort completion
  logic tx_drop_now;
  logic tx_end_evt;

  assign tx_end_evt    = i_tx_sent || i_bus_error || i_tx_arb_lost || i_halt_entry;
  // nothing on the bus: drop at once
  assign tx_drop_now   = wr_txq && st_ff.tx_queue_enable && !wr_data[BIT_ENABLE] && !i_tx_scheduled;
  assign tx_abort_done = tx_drop_now || (st_ff.tx_abort_pend && tx_end_evt);

  // ==========================================================================
  // Next state
  always_comb begin
    nxt = st_ff;

    // ---- receive protection window
    if (i_crc_start) begin
      nxt.rx_prot = 1'b1;
      nxt.rx_sel  = 1'b0;
    end
    if (i_filter_done) begin
      nxt.rx_sel = i_rx_to_queue;
      if (!i_rx_to_queue) begin
        nxt.rx_prot = 1'b0;
      end
    end
    if (st_ff.rx_sel && (i_rx_stored || i_bus_error || i_eof7_end)) begin
      // released on store, error or 7th EOF bit
      nxt.rx_prot = 1'b0;
      nxt.rx_sel  = 1'b0;
    end

    // ---- receive pointers and count
    if (rx_take) begin
      nxt.rx_wr = st_ff.rx_wr + 2'h1;
    end
    if (rx_take && rx_full) begin
      nxt.rx_rd = st_ff.rx_rd + 2'h1;
    end else if (adv_ok) begin
      nxt.rx_rd = st_ff.rx_rd + 2'h1;
    end
    if (rx_take && !rx_full && !adv_ok) begin
      nxt.rx_cnt = st_ff.rx_cnt + 3'h1;
    end else if (adv_ok && !(rx_take && !rx_full)) begin
      nxt.rx_cnt = st_ff.rx_cnt - 3'h1;
    end

    // ---- lost flag: write 0 clears unless held after 6th EOF bit
    if (st_ff.lost_hold != 3'h0) begin
      nxt.lost_hold = st_ff.lost_hold - 3'h1;
    end
    if (wr_rxq && !wr_data[BIT_RX_LOST] && (st_ff.lost_hold == 3'h0)) begin
      nxt.rx_lost = 1'b0;
    end
    if (lost_evt) begin
      nxt.rx_lost   = 1'b1;
      nxt.lost_hold = LOST_PROT_CYC;
    end

    // ---- receive enable
    if (wr_rxq) begin
      if (wr_data[BIT_ENABLE]) begin
        nxt.rx_queue_enable = 1'b1;
      end else if (!st_ff.rx_prot) begin
        nxt.rx_queue_enable = 1'b0;
      end
    end
    if (!nxt.rx_queue_enable) begin
      nxt.rx_wr  = 2'h0;
      nxt.rx_rd  = 2'h0;
      nxt.rx_cnt = 3'h0;
    end

    // ---- transmit queue
    if (i_tx_push && st_ff.tx_queue_enable && (st_ff.tx_cnt != CNT_FULL)) begin
      nxt.tx_wr  = st_ff.tx_wr + 2'h1;
      nxt.tx_cnt = nxt.tx_cnt + 3'h1;
    end
    if (i_tx_sent && (st_ff.tx_cnt != 3'h0)) begin
      nxt.tx_rd  = st_ff.tx_rd + 2'h1;
      nxt.tx_cnt = nxt.tx_cnt - 3'h1;
    end
    if (wr_txq) begin
      nxt.tx_queue_enable = wr_data[BIT_ENABLE];
      if (wr_data[BIT_ENABLE]) begin
        nxt.tx_aborted = 1'b0;
      end else if (st_ff.tx_queue_enable) begin
        nxt.tx_aborted    = 1'b1;
        nxt.tx_abort_pend = i_tx_scheduled;
      end
    end
    if (tx_abort_done) begin
      // queue emptied at once if nothing is scheduled, else after the active frame ends
      nxt.tx_abort_pend = 1'b0;
      nxt.tx_cnt        = 3'h0;
      nxt.tx_wr         = 2'h0;
      nxt.tx_rd         = 2'h0;
    end

    // ---- interrupts
    nxt.irq_stat = nxt_stat;
    if (wr_ien) begin
      nxt.irq_en = wr_data[IRQ_N-1:0];
    end
    nxt.irq = |(nxt.irq_stat & nxt.irq_en);

    // ---- read data for the coming data phase
    nxt.rdata = '0;
    if (rd_en) begin
      case (rd_addr)
        ADDR_RXQ_CTRL: nxt.rdata[7:0]       = rxq_view;
        ADDR_RXQ_ADV:  nxt.rdata[1:0]       = st_ff.rx_rd;
        ADDR_TXQ_CTRL: nxt.rdata[7:0]       = txq_view;
        ADDR_IRQ_STAT: nxt.rdata[IRQ_N-1:0] = st_ff.irq_stat;
        ADDR_IRQ_EN:   nxt.rdata[IRQ_N-1:0] = st_ff.irq_en;
        default:       nxt.rdata            = '0;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff          <= '0;
      st_ff.rx_cnt   <= RXQ_RESET[CNT_LSB+2:CNT_LSB];
      st_ff.tx_cnt   <= TXQ_RESET[CNT_LSB+2:CNT_LSB];
    end else begin
      st_ff <= nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // Zero-wait slave: always ready, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = st_ff.rdata;
  assign o_rx_accept = st_ff.rx_queue_enable;
  assign o_rx_wr_ptr = st_ff.rx_wr;
  assign o_rx_rd_ptr = st_ff.rx_rd;
  assign o_tx_enable = st_ff.tx_queue_enable;
  assign o_tx_wr_ptr = st_ff.tx_wr;
  assign o_tx_rd_ptr = st_ff.tx_rd;
  assign o_irq       = st_ff.irq;

  // i_hsize is accepted for any word transfer; only the low byte lane matters
  logic unused_hsize;
  assign unused_hsize = ^i_hsize;

endmodule

//--- tb/cmf_chk.sv
`timescale 1ns/1ps
module cmf_chk
  import cmf_pkg::*;
#(
  parameter int unsigned QDEPTH = 4
)(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        i_crc_start,
  input wire logic        i_filter_done,
  input wire logic        i_rx_to_queue,
  input wire logic        i_eof7_end,
  input wire logic        i_rx_stored,
  input wire logic        i_bus_error,
  input wire logic        i_tx_push,
  input wire logic        o_rx_accept,
  input wire logic [1:0]  o_rx_wr_ptr,
  input wire logic [1:0]  o_rx_rd_ptr,
  input wire logic        o_tx_enable,
  input wire logic [1:0]  o_tx_wr_ptr
);
  // ==========================================
  // Helper logic
  logic acc, wr_rx, wr_tx, rel, prot_ff, nxt_prot;
  assign acc   = i_hsel && i_hready && i_htrans[1];
  assign wr_rx = acc && i_hwrite && (i_haddr == ADDR_RXQ_CTRL);
  assign wr_tx = acc && i_hwrite && (i_haddr == ADDR_TXQ_CTRL);
  // Frame not ours, stored, errored, or the last EOF bound
  assign rel   = (i_filter_done && !i_rx_to_queue) || i_rx_stored || i_bus_error || i_eof7_end;
  always_comb begin
    nxt_prot = i_crc_start || (prot_ff && !rel);
  end
  always_ff @(posedge i_clk) begin
    prot_ff <= !i_rst && nxt_prot;
  end

  // ==========================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  bus_answer_ok_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  rx_wr_step_a: assert property (o_rx_accept && $past(o_rx_accept) && $changed(o_rx_wr_ptr) |->
    $past(i_rx_stored) && o_rx_wr_ptr == $past(o_rx_wr_ptr) + 2'h1)
    else $error("receive write pointer moved wrongly");
  rx_rd_step_a: assert property (o_rx_accept && $past(o_rx_accept) && $changed(o_rx_rd_ptr) |->
    o_rx_rd_ptr == $past(o_rx_rd_ptr) + 2'h1)
    else $error("receive read pointer skipped");
  rx_en_rise_a: assert property ($rose(o_rx_accept) |-> $past(wr_rx, 2))
    else $error("receive enable rose without a write");
  rx_en_fall_a: assert property ($fell(o_rx_accept) |-> $past(wr_rx, 2))
    else $error("receive enable fell without a write");
  rx_guard_a: assert property (prot_ff && o_rx_accept && !rel |=> o_rx_accept)
    else $error("receive enable cleared while protected");
  tx_push_step_a: assert property (o_tx_enable && $past(o_tx_enable) && $changed(o_tx_wr_ptr) |->
    $past(i_tx_push) && o_tx_wr_ptr == $past(o_tx_wr_ptr) + 2'h1)
    else $error("transmit write pointer moved wrongly");
  tx_en_rise_a: assert property ($rose(o_tx_enable) |-> $past(wr_tx, 2))
    else $error("transmit enable rose without a write");
  cover property (prot_ff && i_rx_stored);
  cover property ($fell(o_rx_accept));
  cover property (o_tx_enable && i_tx_push);
endmodule

bind cmf_top cmf_chk #(.QDEPTH(QDEPTH)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_crc_start(i_crc_start),
  .i_filter_done(i_filter_done), .i_rx_to_queue(i_rx_to_queue), .i_eof7_end(i_eof7_end),
  .i_rx_stored(i_rx_stored), .i_bus_error(i_bus_error), .i_tx_push(i_tx_push), .o_rx_accept(o_rx_accept),
  .o_rx_wr_ptr(o_rx_wr_ptr), .o_rx_rd_ptr(o_rx_rd_ptr), .o_tx_enable(o_tx_enable), .o_tx_wr_ptr(o_tx_wr_ptr));

//--- tb/cmf_eng_model.sv
`timescale 1ns/1ps
module cmf_eng_model (
  input  wire logic       i_clk,
  input  wire logic       i_req,
  input  wire logic [1:0] i_op,
  input  wire logic [3:0] i_arg,
  output logic            o_done,
  output logic            o_crc_start,
  output logic            o_filter_done,
  output logic            o_rx_to_queue,
  output logic            o_eof6_end,
  output logic            o_eof7_end,
  output logic            o_rx_stored,
  output logic            o_bus_error,
  output logic            o_overwrite_mode,
  output logic            o_tx_push,
  output logic            o_tx_scheduled,
  output logic            o_tx_sent,
  output logic            o_tx_arb_lost,
  output logic            o_halt_entry
);
  // ==========================================
  // One-cycle event pulses and frame levels
  logic [8:0] pls  = 9'h0;
  logic [3:0] lv   = 4'h0;
  logic       done = 1'b0;
  assign {o_halt_entry, o_tx_arb_lost, o_tx_sent, o_tx_push, o_eof7_end, o_bus_error, o_rx_stored, o_eof6_end,
          o_crc_start} = pls;
  assign {o_filter_done, o_rx_to_queue, o_overwrite_mode, o_tx_scheduled} = lv;
  assign o_done = done;
  task automatic ev(input int k);
    @(posedge i_clk);
    pls <= 9'h1 << k;
    @(posedge i_clk);
    pls <= 9'h0;
    @(negedge i_clk);
  endtask

  // ==========================================
  // Frame phases
  task automatic head(input logic sel);
    ev(0);
    repeat ($urandom_range(0, 2)) @(posedge i_clk);
    @(posedge i_clk);
    lv[3] <= 1'b1;
    lv[2] <= sel;
    @(posedge i_clk);
    lv[3] <= 1'b0;
    // Verdict means nothing outside the pulse
    lv[2] <= !sel;
    @(negedge i_clk);
  endtask
  task automatic tail(input logic err);
    ev(1);
    // store or error, seventh bit last
    ev(err ? 3 : 2);
    ev(4);
  endtask
  task automatic lvl(input logic ow, input logic sch);
    @(posedge i_clk);
    lv[1] <= ow;
    lv[0] <= sch;
    @(negedge i_clk);
  endtask

  // ==========================================
  // Request handshake: done stands until the request drops
  always begin
    @(posedge i_clk);
    if (i_req && !done) begin
      case (i_op)
        2'h0:    ev(i_arg);
        2'h1:    head(i_arg[0]);
        2'h2:    tail(i_arg[0]);
        default: lvl(i_arg[0], i_arg[1]);
      endcase
      done <= 1'b1;
    end else if (!i_req) begin
      done <= 1'b0;
    end
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import cmf_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        rd_on = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hrdy, irq, rx_acc, tx_en, crc, fdone, toq, eof6, eof7, stored, berr, ovw, push, sched, sent, arb, halt;
  logic [1:0]  rx_wp, rx_rp, tx_wp, tx_rp;
  logic        eng_req = 1'b0;
  logic        eng_done;
  logic [1:0]  eng_op = 2'h0;
  logic [3:0]  eng_arg = 4'h0;
  logic [31:0] exp_q[$];
  int          fail_count = 0;
  int          checks = 0;
  int          k, n;
  int          ab[5] = '{0, 6, 3, 7, 8};

  always #2.5 clk = ~clk;
  cmf_top #(.QDEPTH(4)) DUT (
    .i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hready(hrdy), .i_hwdata(hwdata), .o_hreadyout(hrdy), .o_hresp(), .o_hrdata(hrdata),
    .i_crc_start(crc), .i_filter_done(fdone), .i_rx_to_queue(toq), .i_eof6_end(eof6), .i_eof7_end(eof7),
    .i_rx_stored(stored), .i_bus_error(berr), .i_overwrite_mode(ovw), .i_tx_push(push), .i_tx_scheduled(sched),
    .i_tx_sent(sent), .i_tx_arb_lost(arb), .i_halt_entry(halt), .o_rx_accept(rx_acc), .o_rx_wr_ptr(rx_wp),
    .o_rx_rd_ptr(rx_rp), .o_tx_enable(tx_en), .o_tx_wr_ptr(tx_wp), .o_tx_rd_ptr(tx_rp), .o_irq(irq));
  cmf_eng_model u_eng (
    .i_clk(clk), .i_req(eng_req), .i_op(eng_op), .i_arg(eng_arg), .o_done(eng_done), .o_crc_start(crc),
    .o_filter_done(fdone), .o_rx_to_queue(toq), .o_eof6_end(eof6),
    .o_eof7_end(eof7), .o_rx_stored(stored), .o_bus_error(berr), .o_overwrite_mode(ovw), .o_tx_push(push),
    .o_tx_scheduled(sched), .o_tx_sent(sent), .o_tx_arb_lost(arb), .o_halt_entry(halt));

  // ==========================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_rdy();
    int i;
    @(posedge clk);
    for (i = 0; hrdy !== 1'b1 && i < 64; i++) @(posedge clk);
    if (i == 64) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_on  <= !w;
    wait_rdy();
    rd_on  <= 1'b0;
    hwdata <= ~d;
    @(negedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Engine request held until done is seen at a rising edge
  task automatic eng(input logic [1:0] op, input logic [3:0] arg);
    int i;
    @(posedge clk);
    eng_req <= 1'b1;
    eng_op  <= op;
    eng_arg <= arg;
    @(posedge clk);
    for (i = 0; eng_done !== 1'b1 && i < 300; i++) @(posedge clk);
    eng_req <= 1'b0;
    if (i == 300) begin
      fail_count++;
      complete_run();
    end
  endtask
  always @(negedge clk) begin
    if (rd_on) chk(hrdata, exp_q.pop_front());
  end
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(36766));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_RXQ_CTRL, 32'h80);
    rd(ADDR_TXQ_CTRL, 32'h80);
    rd(ADDR_IRQ_STAT, 32'h0);
    wr(32'h10, $urandom);
    rd(32'h10, 32'h0);
    $display("test reset done");
    // queue mode assumed, enable only then
    wr(ADDR_RXQ_CTRL, 32'h1);
    for (k = 1; k <= 4; k++) begin
      eng(2'h1, 4'h1);
      eng(2'h2, 4'h0);
      rd(ADDR_RXQ_CTRL, {24'h0, 1'b0, k == 3, k == 4, 1'b0, k[2:0], 1'b1});
      chk(rx_wp, k[1:0]);
    end
    chk(irq, 1'b0);
    wr(ADDR_IRQ_EN, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1);
    wr(ADDR_IRQ_CLR, 32'hf);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    wr(ADDR_RXQ_ADV, 32'hff);
    rd(ADDR_RXQ_CTRL, 32'h47);
    chk(rx_rp, 2'h1);
    $display("test receive fill done");
    eng(2'h1, 4'h1);
    eng(2'h2, 4'h0);
    wr(ADDR_IRQ_EN, 32'h2);
    wr(ADDR_IRQ_CLR, 32'hf);
    eng(2'h3, 4'h1);
    eng(2'h1, 4'h1);
    eng(2'h2, 4'h0);
    rd(ADDR_RXQ_CTRL, 32'h39);
    chk({rx_wp, rx_rp}, 4'ha);
    chk(irq, 1'b1);
    wr(ADDR_RXQ_ADV, 32'hff);
    chk(rx_rp, 2'h2);
    wr(ADDR_IRQ_CLR, 32'hf);
    wr(ADDR_RXQ_CTRL, 32'h0);
    chk(rx_acc, 1'b0);
    rd(ADDR_RXQ_CTRL, 32'h80);
    $display("test overwrite done");
    wr(ADDR_RXQ_CTRL, 32'h1);
    eng(2'h1, 4'h0);
    wr(ADDR_RXQ_CTRL, 32'h0);
    chk(rx_acc, 1'b0);
    wr(ADDR_RXQ_CTRL, 32'h1);
    eng(2'h1, 4'h1);
    wr(ADDR_RXQ_CTRL, 32'h0);
    chk(rx_acc, 1'b1);
    eng(2'h2, 4'h1);
    wr(ADDR_RXQ_CTRL, 32'h0);
    chk(rx_acc, 1'b0);
    $display("test protection done");
    // operation mode assumed for transmit writes
    wr(ADDR_TXQ_CTRL, 32'h1);
    chk(tx_en, 1'b1);
    rd(ADDR_TXQ_CTRL, 32'h81);
    n = $urandom_range(1, 3);
    repeat (n) eng(2'h0, 4'h5);
    rd(ADDR_TXQ_CTRL, {28'h0, n[2:0], 1'b1});
    repeat (5 - n) eng(2'h0, 4'h5);
    rd(ADDR_TXQ_CTRL, 32'h49);
    chk(tx_wp, 2'h0);
    eng(2'h0, 4'h6);
    rd(ADDR_TXQ_CTRL, 32'h07);
    chk(tx_rp, 2'h1);
    for (k = 0; k < 5; k++) begin
      eng(2'h3, {2'h0, k > 0, 1'b0});
      wr(ADDR_TXQ_CTRL, 32'h0);
      if (k > 0) eng(2'h0, ab[k][3:0]);
      eng(2'h3, 4'h0);
      rd(ADDR_TXQ_CTRL, 32'h80);
      wr(ADDR_TXQ_CTRL, 32'h1);
      repeat (2) eng(2'h0, 4'h5);
    end
    rd(ADDR_IRQ_STAT, 32'hc);
    $display("test transmit done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({irq, tx_en}, 2'h0);
    rd(ADDR_TXQ_CTRL, 32'h80);
    $display("test second reset done");
    complete_run();
  end
endmodule
